/* File: fpc_pkg.sv */
// fpc_pkg: constants, types and encodings for the fetch, pc and stack core
// assumes a single 50 MHz clock domain and a 16-bit program word
package fpc_pkg;

    // program counter and program memory geometry
    localparam int FPC_PC_W = 13;
    localparam int FPC_PAGE_W = 8;
    localparam int FPC_WORD_W = 16;
    localparam int FPC_STACK_DEPTH = 8;

    // reset values
    localparam logic [12:0] FPC_RESET_PC = 13'h0000;
    localparam logic [12:0] FPC_INT_VECTOR = 13'h0004;
    localparam logic [7:0] FPC_RESET_BYTE = 8'h00;
    localparam logic [15:0] FPC_RESET_WORD = 16'h0000;

    // register port offsets
    localparam logic [1:0] FPC_REG_PC_LOW_BYTE = 2'h0;
    localparam logic [1:0] FPC_REG_STATUS = 2'h1;
    localparam logic [1:0] FPC_REG_ACC = 2'h2;
    localparam logic [1:0] FPC_REG_MEM = 2'h3;

    // phase_clocks sequence, gray coded
    typedef enum logic [1:0] {
        FPC_T1 = 2'h0,
        FPC_T2 = 2'h1,
        FPC_T3 = 2'h3,
        FPC_T4 = 2'h2
    } fpc_phase_t;

    // instruction classes in bits 15:13
    typedef enum logic [2:0] {
        FPC_C_MISC = 3'h0,
        FPC_C_ALUI = 3'h1,
        FPC_C_ALUM = 3'h2,
        FPC_C_MOVM = 3'h3,
        FPC_C_JUMP_INSTR = 3'h6,
        FPC_C_CALL = 3'h7
    } fpc_class_t;

    // misc sub operations in bits 3:0
    localparam logic [3:0] FPC_M_NOP = 4'h0;
    localparam logic [3:0] FPC_M_RETURN_SUBROUTINE = 4'h1;
    localparam logic [3:0] FPC_M_RETURN_INTERRUPT = 4'h2;
    localparam logic [3:0] FPC_M_SZ = 4'h3;
    localparam logic [3:0] FPC_M_SNZ = 4'h4;
    localparam logic [3:0] FPC_M_PCLW = 4'h5;

    // alu functions in bits 11:8
    typedef enum logic [3:0] {
        FPC_A_ADD = 4'h0, FPC_A_ADC = 4'h1, FPC_A_SUB = 4'h2, FPC_A_SBC = 4'h3,
        FPC_A_AND = 4'h4, FPC_A_OR = 4'h5, FPC_A_XOR = 4'h6, FPC_A_CPL = 4'h7,
        FPC_A_RR = 4'h8, FPC_A_RRC = 4'h9, FPC_A_RL = 4'ha, FPC_A_RLC = 4'hb,
        FPC_A_INC = 4'hc, FPC_A_DEC = 4'hd, FPC_A_DECIMAL_ADJUST = 4'he, FPC_A_MOV = 4'hf
    } fpc_alu_t;

    // status flags
    typedef struct packed {
        logic ov;
        logic z;
        logic ac;
        logic c;
    } fpc_status_t;

    // alu answer: result byte with its flags
    typedef struct packed {
        logic [7:0] res;
        fpc_status_t st;
    } fpc_alu_out_t;

endpackage : fpc_pkg

/* File: fpc_core.sv */
// fpc_core: four-phase sequencer, prefetch pipeline, 13-bit pc, return stack and 8-bit alu
// assumes program memory answers PM_ADDR by the T4 edge, IRQ is an asynchronous pin
`timescale 1ns/1ps
module fpc_core
    import fpc_pkg::*;
#(
    parameter int STACK_DEPTH = FPC_STACK_DEPTH,
    parameter logic [12:0] INT_VECTOR = FPC_INT_VECTOR
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // program memory
    output logic [12:0] PM_ADDR,
    output logic PM_RD,
    input wire logic [15:0] PM_DATA,
    // interrupt request
    input wire logic IRQ,
    output logic INT_ACK,
    // register port
    input wire logic [1:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // observation
    output logic [1:0] PHASE,
    output logic STACK_FULL
);

    localparam int SP_W = $clog2(STACK_DEPTH);

    // refuse depths the wrapping pointer cannot serve
    if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_depth_check
        $error("STACK_DEPTH must be a power of two, at least 2");
    end

    fpc_phase_t phase_ff;
    logic [12:0] pc_ff;
    logic [12:0] fetch_addr_ff;
    logic pm_rd_ff;
    logic [15:0] ir_ff;
    logic ir_valid_ff;
    logic [12:0] stk_mem [STACK_DEPTH];
    logic [SP_W-1:0] sp_ff;
    logic [SP_W:0] cnt_ff;
    logic [SP_W:0] nxt_cnt;
    logic stack_full_ff;
    logic irq_s1_ff;
    logic irq_s2_ff;
    logic irq_d_ff;
    logic int_pend_ff;
    logic int_ack_ff;
    logic [7:0] acc_ff;
    logic [7:0] mem_ff;
    fpc_status_t status_ff;
    logic low_byte_pend_ff;
    logic [7:0] low_byte_val_ff;
    logic [7:0] rdata_ff;

    // decode of the instruction in execution
    logic at_t4;
    logic exec;
    fpc_class_t cls;
    logic [3:0] sub;
    logic is_jump, is_call, is_return, is_pclw, is_alu, skip_taken, instr_xfer;
    logic do_ack, do_bus_low_byte, do_push, do_pop, stack_full;
    logic [12:0] stk_top;
    fpc_alu_out_t alu_o;

    assign at_t4 = (phase_ff == FPC_T4);
    assign exec = at_t4 && ir_valid_ff;
    assign cls = fpc_class_t'(ir_ff[15:13]);
    assign sub = ir_ff[3:0];
    assign is_jump = exec && (cls == FPC_C_JUMP_INSTR);
    assign is_call = exec && (cls == FPC_C_CALL);
    assign is_return = exec && (cls == FPC_C_MISC) &&
                       (sub == FPC_M_RETURN_SUBROUTINE || sub == FPC_M_RETURN_INTERRUPT);
    assign is_pclw = exec && (cls == FPC_C_MISC) && (sub == FPC_M_PCLW);
    assign is_alu = exec && (cls == FPC_C_ALUI || cls == FPC_C_ALUM);
    assign skip_taken = exec && (cls == FPC_C_MISC) &&
                        ((sub == FPC_M_SZ && acc_ff == 8'h00) || (sub == FPC_M_SNZ && acc_ff != 8'h00));
    assign instr_xfer = is_jump || is_call || is_return || is_pclw;
    assign stack_full = (cnt_ff == (SP_W+1)'(STACK_DEPTH));
    // acknowledge only beside an instruction that keeps the prefetch, never with a full stack
    assign do_ack = int_pend_ff && exec && !instr_xfer && !skip_taken && !stack_full;
    assign do_bus_low_byte = low_byte_pend_ff && at_t4 && !instr_xfer && !skip_taken && !do_ack;
    assign do_push = is_call || do_ack;
    assign do_pop = is_return;
    assign stk_top = stk_mem[sp_ff - SP_W'(1)];

    // alu: 8-bit operation with flag update
    function automatic fpc_alu_out_t alu_calc(input logic [3:0] f, input logic [7:0] a,
                                              input logic [7:0] b, input fpc_status_t s);
        fpc_alu_out_t o;
        logic [7:0] bx;
        logic cin;
        logic [8:0] s9;
        logic [4:0] n5;
        logic [8:0] d9;
        o.res = a;
        o.st = s;
        bx = b;
        cin = 1'b0;
        s9 = 9'h000;
        n5 = 5'h00;
        d9 = 9'h000;
        case (fpc_alu_t'(f))
            FPC_A_ADD, FPC_A_ADC, FPC_A_SUB, FPC_A_SBC: begin
                bx = (f == FPC_A_SUB || f == FPC_A_SBC) ? ~b : b;
                cin = (f == FPC_A_ADD) ? 1'b0 : (f == FPC_A_SUB) ? 1'b1 : s.c;
                s9 = {1'b0, a} + {1'b0, bx} + {8'h00, cin};
                n5 = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
                o.res = s9[7:0];
                o.st.c = s9[8]; // carry, or no-borrow for subtract
                o.st.ac = n5[4];
                o.st.ov = (a[7] == bx[7]) && (s9[7] != a[7]);
            end
            FPC_A_AND: o.res = a & b;
            FPC_A_OR: o.res = a | b;
            FPC_A_XOR: o.res = a ^ b;
            FPC_A_CPL: o.res = ~b;
            FPC_A_RR: o.res = {b[0], b[7:1]};
            FPC_A_RRC: begin
                o.res = {s.c, b[7:1]};
                o.st.c = b[0];
            end
            FPC_A_RL: o.res = {b[6:0], b[7]};
            FPC_A_RLC: begin
                o.res = {b[6:0], s.c};
                o.st.c = b[7];
            end
            FPC_A_INC: o.res = b + 8'h01;
            FPC_A_DEC: o.res = b - 8'h01;
            FPC_A_DECIMAL_ADJUST: begin
                d9 = {1'b0, a};
                if (a[3:0] > 4'h9 || s.ac) begin
                    d9 = d9 + 9'h006;
                end
                if (d9[7:4] > 4'h9 || s.c || d9[8]) begin
                    d9 = d9 + 9'h060;
                end
                o.res = d9[7:0];
                o.st.c = s.c | d9[8];
            end
            default: o.res = b;
        endcase
        // rotates and moves leave the zero flag alone
        if (f < FPC_A_RR || f == FPC_A_INC || f == FPC_A_DEC || f == FPC_A_DECIMAL_ADJUST) begin
            o.st.z = (o.res == 8'h00);
        end
        return o;
    endfunction : alu_calc

    assign alu_o = alu_calc(ir_ff[11:8], acc_ff, (cls == FPC_C_ALUI) ? ir_ff[7:0] : mem_ff, status_ff);

    // phase sequencer: T1, T2, T3, T4 make one instruction cycle
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            phase_ff <= FPC_T1;
        end else begin
            case (phase_ff)
                FPC_T1: phase_ff <= FPC_T2;
                FPC_T2: phase_ff <= FPC_T3;
                FPC_T3: phase_ff <= FPC_T4;
                default: phase_ff <= FPC_T1;
            endcase
        end
    end

    // program counter: increment and fetch at T1, redirect at T4
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            pc_ff <= FPC_RESET_PC;
            fetch_addr_ff <= FPC_RESET_PC;
            pm_rd_ff <= 1'b0;
        end else begin
            pm_rd_ff <= (phase_ff == FPC_T1);
            if (phase_ff == FPC_T1) begin
                fetch_addr_ff <= pc_ff;
                pc_ff <= pc_ff + 13'h0001;
            end else if (is_jump || is_call) begin
                pc_ff <= ir_ff[12:0];
            end else if (is_return) begin
                pc_ff <= stk_top;
            end else if (do_ack) begin
                pc_ff <= INT_VECTOR;
            end else if (is_pclw) begin
                pc_ff <= {pc_ff[12:8], acc_ff}; // upper bits kept: same page
            end else if (do_bus_low_byte) begin
                pc_ff <= {pc_ff[12:8], low_byte_val_ff};
            end
        end
    end

    // instruction register: prefetched word, flushed on any redirect or taken skip
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            ir_ff <= FPC_RESET_WORD;
            ir_valid_ff <= 1'b0;
        end else if (at_t4) begin
            ir_ff <= PM_DATA;
            ir_valid_ff <= !(instr_xfer || skip_taken || do_ack || do_bus_low_byte);
        end
    end

    // return stack: wrapping pointer, count saturates at the depth
    always_comb begin
        nxt_cnt = cnt_ff;
        if (do_push && !stack_full) begin
            nxt_cnt = cnt_ff + (SP_W+1)'(1);
        end else if (do_pop && cnt_ff != '0) begin
            nxt_cnt = cnt_ff - (SP_W+1)'(1);
        end
    end

    always_ff @(posedge MCLK) begin
        if (do_push) begin
            stk_mem[sp_ff] <= is_call ? pc_ff : fetch_addr_ff;
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            sp_ff <= '0;
            cnt_ff <= '0;
            stack_full_ff <= 1'b0;
        end else begin
            if (do_push) begin
                sp_ff <= sp_ff + SP_W'(1); // overflow wraps onto the oldest slot
            end else if (do_pop) begin
                sp_ff <= sp_ff - SP_W'(1);
            end
            cnt_ff <= nxt_cnt;
            stack_full_ff <= (nxt_cnt == (SP_W+1)'(STACK_DEPTH));
        end
    end

    // interrupt: synchronise the pin, latch rising edges, clear on acknowledge
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            irq_s1_ff <= 1'b0;
            irq_s2_ff <= 1'b0;
            irq_d_ff <= 1'b0;
            int_pend_ff <= 1'b0;
            int_ack_ff <= 1'b0;
        end else begin
            irq_s1_ff <= IRQ;
            irq_s2_ff <= irq_s1_ff;
            irq_d_ff <= irq_s2_ff;
            int_ack_ff <= do_ack;
            if (irq_s2_ff && !irq_d_ff) begin
                int_pend_ff <= 1'b1; // a new edge wins over the clear
            end else if (do_ack) begin
                int_pend_ff <= 1'b0;
            end
        end
    end

    // working registers: accumulator, data byte and status
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            acc_ff <= FPC_RESET_BYTE;
            mem_ff <= FPC_RESET_BYTE;
            status_ff <= '0;
        end else if (is_alu) begin
            status_ff <= alu_o.st;
            if (cls == FPC_C_ALUM && ir_ff[12]) begin
                mem_ff <= alu_o.res; // result-to-memory form
            end else begin
                acc_ff <= alu_o.res;
            end
        end else if (exec && cls == FPC_C_MOVM) begin
            mem_ff <= ir_ff[7:0];
        end
    end

    // register port: pc low byte writes queue a page jump, reads answer next cycle
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            low_byte_pend_ff <= 1'b0;
            low_byte_val_ff <= FPC_RESET_BYTE;
            rdata_ff <= FPC_RESET_BYTE;
        end else begin
            if (REG_WR && REG_ADDR == FPC_REG_PC_LOW_BYTE) begin
                low_byte_pend_ff <= 1'b1;
                low_byte_val_ff <= REG_WDATA;
            end else if (do_bus_low_byte) begin
                low_byte_pend_ff <= 1'b0;
            end
            if (!REG_RD) begin
                rdata_ff <= 8'h00;
            end else if (REG_ADDR == FPC_REG_PC_LOW_BYTE) begin
                rdata_ff <= pc_ff[7:0];
            end else if (REG_ADDR == FPC_REG_STATUS) begin
                rdata_ff <= {4'h0, status_ff};
            end else if (REG_ADDR == FPC_REG_ACC) begin
                rdata_ff <= acc_ff;
            end else begin
                rdata_ff <= mem_ff;
            end
        end
    end

    // outputs straight from flip-flops
    assign PM_ADDR = fetch_addr_ff;
    assign PM_RD = pm_rd_ff;
    assign INT_ACK = int_ack_ff;
    assign REG_RDATA = rdata_ff;
    assign PHASE = phase_ff;
    assign STACK_FULL = stack_full_ff;

    // checks on sequencing, stack and alu
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    property p_phase_cycle;
        (phase_ff == FPC_T1) |=> (phase_ff == FPC_T2) ##1 (phase_ff == FPC_T3) ##1 (phase_ff == FPC_T4) ##1 (phase_ff == FPC_T1);
    endproperty
    a_phase_cycle: assert property (p_phase_cycle) else $error("phase sequence broken");

    property p_fetch_t1;
        (phase_ff == FPC_T1) |=> (PM_ADDR == $past(pc_ff)) && (pc_ff == $past(pc_ff) + 13'h0001) && PM_RD;
    endproperty
    a_fetch_t1: assert property (p_fetch_t1) else $error("fetch or increment missing at T1");

    property p_flush;
        (instr_xfer || skip_taken || do_ack) |=> !ir_valid_ff ##4 (ir_valid_ff || $past(do_bus_low_byte));
    endproperty
    a_flush: assert property (p_flush) else $error("flush not exactly one dummy cycle");

    property p_jump_target;
        (is_jump || is_call) |=> (pc_ff == $past(ir_ff[12:0])) ##1 (PM_ADDR == $past(ir_ff[12:0], 2));
    endproperty
    a_jump_target: assert property (p_jump_target) else $error("jump target not fetched");

    property p_page_jump;
        (is_pclw || do_bus_low_byte) |=> (pc_ff[12:8] == $past(pc_ff[12:8]));
    endproperty
    a_page_jump: assert property (p_page_jump) else $error("low byte jump left the page");

    property p_push;
        do_push |=> (cnt_ff == $past(cnt_ff) + (SP_W+1)'(1)) || (cnt_ff == (SP_W+1)'(STACK_DEPTH));
    endproperty
    a_push: assert property (p_push) else $error("push did not count");

    property p_ret_restore;
        do_pop |=> (pc_ff == $past(stk_top));
    endproperty
    a_ret_restore: assert property (p_ret_restore) else $error("return did not restore pc");

    property p_full_hold;
        (int_pend_ff && stack_full) |=> !INT_ACK;
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("acknowledge with full stack");

    property p_ack_vector;
        do_ack |=> (pc_ff == INT_VECTOR) && INT_ACK &&
                   (!int_pend_ff || ($past(irq_s2_ff) && !$past(irq_d_ff)));
    endproperty
    a_ack_vector: assert property (p_ack_vector) else $error("acknowledge did not vector");

    property p_zero_flag;
        (is_alu && fpc_alu_t'(ir_ff[11:8]) == FPC_A_AND && alu_o.res == 8'h00) |=> status_ff.z;
    endproperty
    a_zero_flag: assert property (p_zero_flag) else $error("zero flag not set");

    c_call: cover property (is_call);
    c_overflow: cover property (is_call && stack_full);
    c_held_irq: cover property (int_pend_ff && stack_full ##[1:200] do_ack);
    c_skip: cover property (skip_taken);

endmodule : fpc_core

/* File: fpc_pmem_model.sv */
// fpc_pmem_model: program memory seen from the core, 8K words of 16 bits
// assumes the core holds PM_ADDR steady for a whole instruction cycle
`timescale 1ns/1ps
module fpc_pmem_model
    import fpc_pkg::*;
(
    // clock
    input wire logic clk,
    // fetch port
    input wire logic [12:0] addr,
    output logic [15:0] data
);
    logic [15:0] mem [0:8191]; // whole 13-bit range
    int lat = 1;
    int age = 0;
    logic [12:0] last_addr = 13'h0000;
    logic [15:0] junk = 16'h5a5a;
    // age of the current address; junk changes every cycle so a stale word never looks valid
    always @(posedge clk) begin
        if (addr !== last_addr) begin
            age <= 0;
            last_addr <= addr;
        end else if (age < 8) begin
            age <= age + 1;
        end
        junk <= ~junk;
    end
    // the word shows only once the access time has run
    assign data = (addr === last_addr && age >= lat) ? mem[addr] : junk;
endmodule : fpc_pmem_model

/* File: tb.sv */
// tb: self-checking bench for fpc_core against a program memory model
// assumes one 50 MHz clock and the core's own instruction encoding
`timescale 1ns/1ps
module tb import fpc_pkg::*; ;
    typedef struct packed {
        logic [3:0] f;
        logic [7:0] a;
        logic [7:0] b;
        logic cin;
        logic [7:0] r;
        logic [3:0] st;
        logic [3:0] m;
    } fpc_row_t;
    logic mclk, rst, pm_rd, irq, int_ack, reg_wr, reg_rd, stack_full;
    logic [12:0] pm_addr, fa;
    logic [15:0] pm_data;
    logic [1:0] reg_addr, phase;
    logic [7:0] reg_wdata, reg_rdata, d;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;
    int acks = 0;
    logic [1:0] ph [4] = '{FPC_T3, FPC_T4, FPC_T1, FPC_T2};
    // alu cases: function, acc, operand, carry in, result, flags {ov,z,ac,c}, flag mask
    fpc_row_t rows [16] = '{
        '{4'h0, 8'h3c, 8'hc4, 1'h0, 8'h00, 4'h5, 4'h5}, '{4'h1, 8'h10, 8'h20, 1'h1, 8'h31, 4'h0, 4'h5},
        '{4'h2, 8'h05, 8'h06, 1'h1, 8'hff, 4'h0, 4'h5}, '{4'h3, 8'h05, 8'h05, 1'h0, 8'hff, 4'h0, 4'h5},
        '{4'h4, 8'hf0, 8'h0f, 1'h0, 8'h00, 4'h4, 4'h4}, '{4'h5, 8'hf0, 8'h0f, 1'h0, 8'hff, 4'h0, 4'h4},
        '{4'h6, 8'haa, 8'haa, 1'h0, 8'h00, 4'h4, 4'h4}, '{4'h7, 8'h00, 8'h5a, 1'h0, 8'ha5, 4'h0, 4'h4},
        '{4'h8, 8'h00, 8'h81, 1'h0, 8'hc0, 4'h0, 4'h0}, '{4'h9, 8'h00, 8'h81, 1'h0, 8'h40, 4'h1, 4'h1},
        '{4'ha, 8'h00, 8'h81, 1'h0, 8'h03, 4'h0, 4'h0}, '{4'hb, 8'h00, 8'h81, 1'h0, 8'h02, 4'h1, 4'h1},
        '{4'hc, 8'h00, 8'hff, 1'h0, 8'h00, 4'h4, 4'h4}, '{4'hd, 8'h00, 8'h01, 1'h0, 8'h00, 4'h4, 4'h4},
        '{4'he, 8'h0f, 8'h00, 1'h0, 8'h15, 4'h0, 4'h4}, '{4'hf, 8'h00, 8'h77, 1'h0, 8'h77, 4'h0, 4'h0}
    };

    fpc_core i_dut (.MCLK(mclk), .RST(rst), .PM_ADDR(pm_addr), .PM_RD(pm_rd), .PM_DATA(pm_data), .IRQ(irq),
        .INT_ACK(int_ack), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
        .REG_RDATA(reg_rdata), .PHASE(phase), .STACK_FULL(stack_full));
    fpc_pmem_model i_pm (.clk(mclk), .addr(pm_addr), .data(pm_data));

    // clock
    initial begin
        mclk = 1'h0;
        forever #10 mclk = ~mclk;
    end
    // cycle ceiling and acknowledge count
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (int_ack === 1'h1) acks <= acks + 1;
        if (cyc == 3000) begin
            miscompares++;
            results();
        end
    end

    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task results;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    task reset_dut;
        @(posedge mclk);
        rst <= 1'h1;
        for (int i = 0; i < 8192; i++) i_pm.mem[i] = 16'h0000;
        repeat (12) @(posedge mclk);
        rst <= 1'h0;
    endtask : reset_dut

    task prog(input logic [12:0] base, input logic [15:0] w[$]);
        foreach (w[i]) i_pm.mem[base + 13'(i)] = w[i];
    endtask : prog

    task bus_wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'h0;
    endtask : bus_wr

    task bus_rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge mclk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'h0;
        #1 v = reg_rdata;
    endtask : bus_rd

    // next fetch: the cycle in which the read pulse shows
    task next_fetch(output logic [12:0] a);
        int k;
        k = 0;
        do begin
            @(posedge mclk);
            #1 k++;
        end while (pm_rd !== 1'h1 && k < 8);
        a = pm_addr;
    endtask : next_fetch

    task wait_fetch(input logic [12:0] t, input int lim);
        int n;
        n = 0;
        fa = ~t;
        while (fa !== t && n < lim) begin
            next_fetch(fa);
            n++;
        end
        chk("fetch", 16'(fa), 16'(t));
    endtask : wait_fetch

    // main sequence
    initial begin
        rst = 1'h1;
        irq = 1'h0;
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_addr = 2'h0;
        reg_wdata = 8'h00;
        // reset values, then a straight run of no-ops and the phase order
        reset_dut();
        #1 chk("reset", {pm_addr, phase, stack_full}, 16'h0000);
        chk("reset out", {int_ack, reg_rdata}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            next_fetch(fa);
            chk("seq fetch", 16'(fa), 16'(i));
        end
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            #1 chk("phase", 16'({pm_rd, phase}), 16'({ph[i % 4] == FPC_T2, ph[i % 4]}));
        end
        // alu table: set carry, load acc, apply the function
        foreach (rows[i]) begin
            reset_dut();
            prog(13'h0000, '{16'h2fff, {15'h1000, rows[i].cin}, {8'h2f, rows[i].a},
                {4'h2, rows[i].f, rows[i].b}, 16'hc004});
            repeat (40) @(posedge mclk);
            bus_rd(FPC_REG_ACC, d);
            chk("alu result", 16'(d), 16'(rows[i].r));
            bus_rd(FPC_REG_STATUS, d);
            chk("alu flags", 16'(d & {4'hf, rows[i].m}), 16'({4'h0, rows[i].st}));
        end
        // call, flush, return, then a jump loop
        reset_dut();
        prog(13'h0000, '{16'he010, 16'h0000, 16'hc002});
        prog(13'h0010, '{16'h2f42, 16'h0001});
        foreach (rows[i]) if (i < 8) begin
            next_fetch(fa);
            chk("call flow", 16'(fa), 16'(i < 5 ? (i < 2 ? i : 13'h00e + i) : (i == 6 ? 3 : 2)));
        end
        // taken and untaken skips, then data byte load and both data byte alu forms, prompt memory
        reset_dut();
        i_pm.lat = 0;
        prog(13'h0000, '{16'h2f00, 16'h0003, 16'h6099, 16'h0004, 16'h2f11, 16'h4000, 16'h6022,
            16'h5000, 16'hc008});
        repeat (48) @(posedge mclk);
        bus_rd(FPC_REG_ACC, d);
        chk("skip acc", 16'(d), 16'h0011);
        bus_rd(FPC_REG_MEM, d);
        chk("skip mem", 16'(d), 16'h0033);
        i_pm.lat = 1;
        // low byte write jumps inside the page; read-only register ignores writes
        reset_dut();
        prog(13'h0000, '{16'hdf20});
        wait_fetch(13'h1f22, 8);
        bus_wr(FPC_REG_PC_LOW_BYTE, 8'h05);
        wait_fetch(13'h1f05, 6);
        next_fetch(fa);
        chk("page run", 16'(fa), 16'h1f06);
        bus_rd(FPC_REG_PC_LOW_BYTE, d);
        chk("pc low", 16'(d), 16'h0007);
        bus_wr(FPC_REG_MEM, 8'h5a);
        bus_rd(FPC_REG_MEM, d);
        chk("ro write", 16'(d), 16'h0000);
        // nine nested calls, interrupt held while full, unwinding
        reset_dut();
        for (int k = 0; k < 9; k++) begin
            i_pm.mem[16 * k] = 16'he000 | 16'(16 * (k + 1));
            i_pm.mem[16 * k + 3] = 16'h0001;
        end
        prog(13'h0004, '{16'h0002});
        prog(13'h0013, '{16'hc013});
        prog(13'h0098, '{16'h0001});
        wait_fetch(13'h0090, 40);
        chk("full", 16'(stack_full), 16'h0001);
        @(posedge mclk);
        irq <= 1'h1;
        wait_fetch(13'h0098, 10);
        chk("held ack", 16'(acks), 16'h0000);
        wait_fetch(13'h0004, 8);
        wait_fetch(13'h0083, 4);
        chk("one ack", 16'(acks), 16'h0001);
        irq <= 1'h0;
        wait_fetch(13'h0012, 40);
        chk("unwound", 16'(stack_full), 16'h0000);
        results();
    end
endmodule : tb
